// file: pkg/iisg_pkg.sv
// Notes on behaviour
// (R1) First state pin follows channel 1 state
// (R2) Second pin in data mode follows channel 2
// (R3) Second pin in interrupt mode is open-drain
// (R4) Control bit 2 picks second pin function
// (R5) Address pin picks chip address; ground disables
// (R6) Serial transfers timed only by host clock
// (R7) Host polls reset-complete flag before commands
// (R8) Host then programs filter, load, gain
// (R9) Lock key write completes configuration
// (R10) Gain set by bits 1:0 at 0x201
// (R11) Gain codes map to 1, 2, 5, 10
// (R12) Gain field resets to unity
// (R13) Host picks gain to fill ADC range
// (R14) Channel states derived from ADC samples
// (R15) Host may read status and samples
// (R16) Before reset complete: outputs low, writes ignored
`default_nettype none
package iisg_pkg;
    // Serial frame layout, 32 bits, most significant first
    localparam int FRAME_BITS  = 32;
    localparam int HEADER_BITS = 16;
    localparam int CHIP_MSB    = 15;
    localparam int CHIP_LSB    = 13;
    localparam int RW_BIT      = 12;
    localparam int ADDR_MSB    = 11;
    // Register offsets
    localparam logic [11:0] ADDR_GAIN       = 12'h201;
    localparam logic [11:0] ADDR_CTRL       = 12'h001;
    localparam logic [11:0] ADDR_INT_STATUS = 12'h002;
    localparam logic [11:0] ADDR_STATUS     = 12'h003;
    localparam logic [11:0] ADDR_SAMPLE     = 12'h004;
    localparam logic [11:0] ADDR_THRESHOLD  = 12'h005;
    localparam logic [11:0] ADDR_LOCK       = 12'h006;
    // Field positions and values
    localparam int PIN_MODE_BIT   = 2;
    localparam int RST_DONE_BIT   = 14;
    localparam logic [15:0] LOCK_KEY       = 16'hADE1;
    localparam logic [1:0]  GAIN_RESET     = 2'h0;
    localparam logic [7:0]  THR_HIGH_RESET = 8'hA0;
    localparam logic [7:0]  THR_LOW_RESET  = 8'h60;
    // Timing
    localparam int CLK_MHZ          = 25;
    localparam int RST_DONE_TIME_NS = 10000;
    localparam int RST_DONE_CYCLES  = RST_DONE_TIME_NS * CLK_MHZ / 1000;
    localparam int IRQ_HIGH_TIME_NS = 1000;
    localparam int IRQ_HIGH_CYCLES  = IRQ_HIGH_TIME_NS * CLK_MHZ / 1000;
endpackage
`default_nettype wire

// file: hdl/iisg_top.sv
`default_nettype none
module iisg_top
    import iisg_pkg::*;
#(
    parameter int RST_WAIT = RST_DONE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_sclk,
    input  wire logic       spi_mosi,
    output var  logic       spi_miso,
    output var  logic       spi_miso_oe,
    input  wire logic [2:0] chip_addr_sel,
    input  wire logic [7:0] adc_sample,
    input  wire logic       adc_sample_valid,
    input  wire logic       adc_sample_chan,
    output var  logic       chan1_state_out,
    output var  logic       chan2_state_or_irq_out,
    output var  logic       chan2_state_or_irq_oe,
    output var  logic [1:0] amplifier_gain_code,
    output var  logic [3:0] amplifier_gain_factor
);

    ////////////////////////////////////////////////////////////////////////
    // Gain code to multiplier
    function automatic logic [3:0] gain_of(input logic [1:0] code);
        case (code)
            2'h0:    gain_of = 4'h1;
            2'h1:    gain_of = 4'h2;
            2'h2:    gain_of = 4'h5;
            default: gain_of = 4'hA;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage feeds only the second
    logic [1:0] cs_sync;
    logic [1:0] sclk_sync;
    logic [1:0] mosi_sync;
    logic [2:0] addr_sel_a;
    logic [2:0] addr_sel_b;
    logic       sclk_prev;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_sync    <= 2'h3;
            sclk_sync  <= 2'h0;
            mosi_sync  <= 2'h0;
            addr_sel_a <= 3'h0;
            addr_sel_b <= 3'h0;
            sclk_prev  <= 1'b0;
        end else begin
            cs_sync    <= {cs_sync[0], spi_cs_n};
            sclk_sync  <= {sclk_sync[0], spi_sclk};
            mosi_sync  <= {mosi_sync[0], spi_mosi};
            addr_sel_a <= chip_addr_sel;
            addr_sel_b <= addr_sel_a;
            sclk_prev  <= sclk_sync[1];
        end
    end

    // Data moves only on host clock edges while selected
    wire cs_active  = ~cs_sync[1];
    wire sclk_rise  = cs_active & sclk_sync[1] & ~sclk_prev;  // R6
    wire sclk_fall  = cs_active & ~sclk_sync[1] & sclk_prev;  // R6

    ////////////////////////////////////////////////////////////////////////
    // Reset-complete counter; flag stays set until the next reset
    logic [15:0] rst_count;
    logic        reset_complete_flag;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_count           <= 16'h0000;
            reset_complete_flag <= 1'b0;
        end else if (!reset_complete_flag) begin
            rst_count           <= rst_count + 16'h0001;
            reset_complete_flag <= (rst_count == 16'(RST_WAIT - 1));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial shifter
    logic [5:0]  bit_count;
    logic [15:0] rx_shift;
    logic [15:0] header;
    logic [15:0] tx_shift;
    logic        frame_done;

    wire [15:0] next_rx     = {rx_shift[14:0], mosi_sync[1]};
    wire        header_end  = sclk_rise & (bit_count == 6'(HEADER_BITS - 1));
    wire        frame_end   = sclk_rise & (bit_count == 6'(FRAME_BITS - 1));
    wire [2:0]  hdr_chip    = next_rx[CHIP_MSB:CHIP_LSB];
    // Grounded address pin means any chip field is accepted
    wire        chip_hit    = (addr_sel_b == 3'h0) | (hdr_chip == addr_sel_b);  // R5
    wire        hdr_is_mine = (addr_sel_b == 3'h0) | (header[CHIP_MSB:CHIP_LSB] == addr_sel_b);
    wire [11:0] rd_addr     = next_rx[ADDR_MSB:0];
    wire [11:0] wr_addr     = header[ADDR_MSB:0];
    wire        wr_commit   = frame_end & ~frame_done & header[RW_BIT] & hdr_is_mine
                              & reset_complete_flag;  // R16

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_count  <= 6'h00;
            rx_shift   <= 16'h0000;
            header     <= 16'h0000;
            frame_done <= 1'b0;
        end else if (!cs_active) begin
            bit_count  <= 6'h00;
            frame_done <= 1'b0;
        end else if (sclk_rise) begin
            rx_shift  <= next_rx;
            bit_count <= frame_end ? 6'h00 : bit_count + 6'h01;
            if (header_end) begin
                header <= next_rx;
            end
            if (frame_end) begin
                frame_done <= 1'b1;  // Extra clocks in one select commit no further write
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [1:0] gain_code;
    logic       pin_irq_mode;
    logic [7:0] thr_high;
    logic [7:0] thr_low;
    logic       config_locked;

    wire wr_gain = wr_commit & (wr_addr == ADDR_GAIN);       // R10
    wire wr_ctrl = wr_commit & (wr_addr == ADDR_CTRL);
    wire wr_thr  = wr_commit & (wr_addr == ADDR_THRESHOLD);
    wire wr_lock = wr_commit & (wr_addr == ADDR_LOCK);
    // Locking protects setup from a stray frame on a shared bus
    wire cfg_ok  = ~config_locked;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gain_code     <= GAIN_RESET;  // R12
            pin_irq_mode  <= 1'b0;
            thr_high      <= THR_HIGH_RESET;
            thr_low       <= THR_LOW_RESET;
            config_locked <= 1'b0;
        end else begin
            if (wr_gain && cfg_ok) begin
                gain_code <= next_rx[1:0];  // R10
            end
            if (wr_ctrl && cfg_ok) begin
                pin_irq_mode <= next_rx[PIN_MODE_BIT];  // R4
            end
            if (wr_thr && cfg_ok) begin
                thr_high <= next_rx[15:8];
                thr_low  <= next_rx[7:0];
            end
            if (wr_lock) begin
                config_locked <= (next_rx == LOCK_KEY);  // R9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample capture and hysteretic compare per channel
    logic [7:0] sample1;
    logic [7:0] sample2;
    logic       state1;
    logic       state2;

    wire above_high = adc_sample > thr_high;
    wire below_low  = adc_sample < thr_low;
    wire next_state = above_high ? 1'b1 : (below_low ? 1'b0
                      : (adc_sample_chan ? state2 : state1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sample1 <= 8'h00;
            sample2 <= 8'h00;
            state1  <= 1'b0;
            state2  <= 1'b0;
        end else if (adc_sample_valid) begin
            if (adc_sample_chan) begin
                sample2 <= adc_sample;
                state2  <= next_state;  // R14
            end else begin
                sample1 <= adc_sample;
                state1  <= next_state;  // R14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample-ready pulse: line released for a short time per sample
    logic [7:0] irq_count;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_count <= 8'h00;
        end else if (adc_sample_valid) begin
            irq_count <= 8'(IRQ_HIGH_CYCLES);
        end else if (irq_count != 8'h00) begin
            irq_count <= irq_count - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data mux
    wire [15:0] ctrl_word   = {13'h0000, pin_irq_mode, 2'h0};
    wire [15:0] int_word    = {1'b0, reset_complete_flag, 14'h0000};  // R7
    wire [15:0] status_word = {13'h0000, config_locked, state2, state1};  // R15
    logic [15:0] read_word;

    always_comb begin
        case (rd_addr)
            ADDR_GAIN:       read_word = {14'h0000, gain_code};
            ADDR_CTRL:       read_word = ctrl_word;
            ADDR_INT_STATUS: read_word = int_word;
            ADDR_STATUS:     read_word = status_word;
            ADDR_SAMPLE:     read_word = {sample2, sample1};  // R15
            ADDR_THRESHOLD:  read_word = {thr_high, thr_low};
            default:         read_word = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit side: loaded after header, shifted on falling edges
    logic tx_enable;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_shift    <= 16'h0000;
            tx_enable   <= 1'b0;
            spi_miso    <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else if (!cs_active) begin
            tx_enable   <= 1'b0;
            spi_miso    <= 1'b0;
            spi_miso_oe <= 1'b0;  // Release shared line when deselected
        end else if (header_end) begin
            tx_shift    <= read_word;
            tx_enable   <= ~next_rx[RW_BIT] & chip_hit;
        end else if (sclk_fall && tx_enable) begin
            spi_miso    <= tx_shift[15];  // R6
            spi_miso_oe <= 1'b1;
            tx_shift    <= {tx_shift[14:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output pins, all registered
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chan1_state_out        <= 1'b0;
            chan2_state_or_irq_out <= 1'b0;
            chan2_state_or_irq_oe  <= 1'b0;
            amplifier_gain_code    <= GAIN_RESET;
            amplifier_gain_factor  <= 4'h1;
        end else begin
            chan1_state_out <= state1 & reset_complete_flag;  // R1 R16
            if (pin_irq_mode) begin
                chan2_state_or_irq_out <= 1'b0;  // R3
                chan2_state_or_irq_oe  <= (irq_count == 8'h00);  // R3
            end else begin
                chan2_state_or_irq_out <= state2 & reset_complete_flag;  // R2 R16
                chan2_state_or_irq_oe  <= 1'b1;  // R2
            end
            amplifier_gain_code   <= gain_code;
            amplifier_gain_factor <= gain_of(gain_code);  // R11
        end
    end

endmodule
`default_nettype wire

// file: testbench/iisg_monitor.sv
`default_nettype none
module iisg_monitor
    import iisg_pkg::*;
#(
    parameter int RST_WAIT = RST_DONE_CYCLES
) (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       spi_cs_n,
    input wire logic       spi_miso_oe,
    input wire logic [7:0] adc_sample,
    input wire logic       adc_sample_valid,
    input wire logic       adc_sample_chan,
    input wire logic       chan1_state_out,
    input wire logic       chan2_state_or_irq_out,
    input wire logic       chan2_state_or_irq_oe,
    input wire logic [1:0] amplifier_gain_code,
    input wire logic [3:0] amplifier_gain_factor
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [15:0] up;
    // Past the flag with margin; assumes thresholds keep their reset values
    wire         ready = up > 16'(RST_WAIT + 4);
    wire         v1    = adc_sample_valid && !adc_sample_chan && ready;
    // Cycles since release, saturating so a long run never wraps into the hold window
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            up <= 16'h0000;
        else if (up != 16'hFFFF)
            up <= up + 16'h0001;
    end
    function automatic logic [3:0] fac(input logic [1:0] c);
        return (c == 2'h0) ? 4'h1 : (c == 2'h1) ? 4'h2 : (c == 2'h2) ? 4'h5 : 4'hA;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    property p_gain_map;
        $past(reset_n) |-> amplifier_gain_factor == fac(amplifier_gain_code);
    endproperty
    a_gain_map: assert property (p_gain_map) else $error("gain factor mismatch");
    property p_gain_rst;
        $rose(reset_n) |-> amplifier_gain_code == 2'h0;
    endproperty
    a_gain_rst: assert property (p_gain_rst) else $error("gain not unity at reset");
    property p_hold_low;
        up < 16'(RST_WAIT) |-> !chan1_state_out && !chan2_state_or_irq_out;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("state out before ready");
    property p_drive_high;
        chan2_state_or_irq_out |-> chan2_state_or_irq_oe;
    endproperty
    a_drive_high: assert property (p_drive_high) else $error("second pin high undriven");
    property p_ch1_high;
        v1 && adc_sample > THR_HIGH_RESET |-> ##[1:3] chan1_state_out;
    endproperty
    a_ch1_high: assert property (p_ch1_high) else $error("ch1 missed high");
    property p_ch1_low;
        v1 && adc_sample < THR_LOW_RESET |-> ##[1:3] !chan1_state_out;
    endproperty
    a_ch1_low: assert property (p_ch1_low) else $error("ch1 missed low");
    property p_oe_start;
        $rose(reset_n) |=> chan2_state_or_irq_oe;
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("pin not driven after reset");
    property p_miso_idle;
        spi_cs_n [*6] |-> !spi_miso_oe;
    endproperty
    a_miso_idle: assert property (p_miso_idle) else $error("miso driven while idle");
endmodule
bind iisg_top iisg_monitor #(.RST_WAIT(RST_WAIT)) u_mon (.clk(clk), .reset_n(reset_n),
    .spi_cs_n(spi_cs_n), .spi_miso_oe(spi_miso_oe), .adc_sample(adc_sample),
    .adc_sample_valid(adc_sample_valid), .adc_sample_chan(adc_sample_chan),
    .chan1_state_out(chan1_state_out), .chan2_state_or_irq_out(chan2_state_or_irq_out),
    .chan2_state_or_irq_oe(chan2_state_or_irq_oe),
    .amplifier_gain_code(amplifier_gain_code), .amplifier_gain_factor(amplifier_gain_factor));
`default_nettype wire

// file: testbench/iisg_host_model.sv
`default_nettype none
module iisg_host_model (
    input  wire logic clk,
    input  wire logic miso_line,
    output var  logic spi_cs_n,
    output var  logic spi_sclk,
    output var  logic spi_mosi
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 8;
    // Serial clock stands low between frames
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end
    // One whole frame, first bit most significant; data moves only while the clock is low
    task automatic xfer(input logic [31:0] f, output logic [15:0] rd);
        rd = 16'h0000;
        @(negedge clk);
        spi_cs_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            spi_mosi = f[i];
            repeat (HALF) @(negedge clk);
            spi_sclk = 1'b1;
            rd = {rd[14:0], miso_line};
            repeat (HALF) @(negedge clk);
            spi_sclk = 1'b0;
        end
        repeat (HALF) @(negedge clk);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        repeat (HALF) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// file: testbench/isolated_input_setup_gain_bench.sv
`default_nettype none
module isolated_input_setup_gain_bench import iisg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WAIT = 2000;
    logic        clk     = 1'b0;
    logic        reset_n = 1'b0;
    logic        flip    = 1'b0;
    logic        valid   = 1'b0;
    logic        chan    = 1'b0;
    logic [2:0]  sel     = 3'h0;
    logic [7:0]  smp     = 8'h00;
    logic [15:0] rd;
    logic [3:0]  gtab [4] = '{4'h1, 4'h2, 4'h5, 4'hA};
    int          n_fail  = 0;
    int          n_tests = 0;
    int          cyc     = 0;
    wire         cs_n, sclk, mosi, miso, miso_oe, c1, c2, c2_oe;
    wire [1:0]   gcode;
    wire [3:0]   gfac;
    // Released miso toggles each clock, but the host samples it every 16 clocks and so reads one fixed level
    wire         miso_line = miso_oe ? miso : flip;
    iisg_top #(.RST_WAIT(WAIT)) u_dut (
        .clk(clk), .reset_n(reset_n), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe(miso_oe), .chip_addr_sel(sel), .adc_sample(smp),
        .adc_sample_valid(valid), .adc_sample_chan(chan), .chan1_state_out(c1),
        .chan2_state_or_irq_out(c2), .chan2_state_or_irq_oe(c2_oe),
        .amplifier_gain_code(gcode), .amplifier_gain_factor(gfac));
    iisg_host_model u_host (.clk(clk), .miso_line(miso_line), .spi_cs_n(cs_n),
        .spi_sclk(sclk), .spi_mosi(mosi));
    always #20 clk = ~clk;
    // Cycle ceiling cuts a hung frame short
    always @(negedge clk) begin
        flip <= ~flip;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            $display("ERROR %0t timeout", $time);
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] cid, input logic [11:0] a, input logic [15:0] d);
        u_host.xfer({cid, 1'b1, a, d}, rd);
    endtask
    task automatic rdk(input logic [11:0] a, input logic [15:0] exp, input string m);
        u_host.xfer({4'h0, a, 16'h0000}, rd);
        chk(rd, exp, m);
    endtask
    // One sample pulse, then time for the two-cycle output delay
    task automatic feed(input logic ch, input logic [7:0] s);
        chan = ch;
        smp = s;
        valid = 1'b1;
        @(negedge clk);
        valid = 1'b0;
        repeat (5) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        chk(16'(gfac), 16'h0001, "gain factor reset");
        wr(3'h0, ADDR_GAIN, 16'h0003);
        feed(1'b0, 8'hF0);
        chk(16'(c1), 16'h0000, "ch1 held");
        rdk(ADDR_GAIN, 16'h0000, "early write");
        rdk(ADDR_INT_STATUS, 16'h0000, "flag early");
        for (int i = 0; i < 20 && !rd[RST_DONE_BIT]; i++)
            u_host.xfer({4'h0, ADDR_INT_STATUS, 16'h0000}, rd);
        chk(16'(rd[RST_DONE_BIT]), 16'h0001, "flag set");
        for (int c = 0; c < 4; c++) begin
            wr(3'h0, ADDR_GAIN, 16'(c));
            chk(16'(gfac), 16'(gtab[c]), "gain factor");
            rdk(ADDR_GAIN, 16'(c), "gain readback");
        end
        feed(1'b0, 8'hC0);
        feed(1'b1, 8'hC0);
        chk({14'h0000, c2, c1}, 16'h0003, "states high");
        rdk(ADDR_SAMPLE, 16'hC0C0, "samples");
        rdk(ADDR_STATUS, 16'h0003, "status");
        feed(1'b0, 8'h20);
        chk(16'(c1), 16'h0000, "ch1 low");
        wr(3'h0, ADDR_CTRL, 16'h0004);
        chk({14'h0000, c2, c2_oe}, 16'h0001, "irq pulls low");
        feed(1'b1, 8'h20);
        chk({14'h0000, c2, c2_oe}, 16'h0000, "irq released");
        repeat (25) @(negedge clk);
        chk({14'h0000, c2, c2_oe}, 16'h0001, "irq low again");
        wr(3'h0, ADDR_CTRL, 16'h0000);
        chk({14'h0000, c2, c2_oe}, 16'h0001, "data mode low");
        sel = 3'h5;
        wr(3'h2, ADDR_GAIN, 16'h0001);
        chk(16'(gcode), 16'h0003, "foreign chip");
        wr(3'h5, ADDR_GAIN, 16'h0002);
        chk(16'(gcode), 16'h0002, "own chip");
        sel = 3'h0;
        wr(3'h0, ADDR_LOCK, LOCK_KEY);
        wr(3'h0, ADDR_GAIN, 16'h0000);
        chk(16'(gcode), 16'h0002, "locked gain");
        rdk(ADDR_STATUS, 16'h0004, "locked status");
        tally_and_finish();
    end
endmodule
`default_nettype wire
